/* File: rtl/pin_select_pkg.sv */
// Shared constants for the remappable pin select block
package pin_select_pkg;
  // Selector and field layout
  localparam int SEL_W = 5;
  localparam int REG_W = 16;
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 8;
  localparam logic [SEL_W-1:0] SEL_TIED = 5'h1f;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h1f;
  localparam logic [SEL_W-1:0] FIELD_RESET = 5'h00;
  localparam logic [SEL_W-1:0] FUNC_NONE = 5'h00;
  localparam int FUNC_CNT = 32;
  // Output maps: eleven registers, pins 0 to 21; eight on small parts
  localparam int NUM_MAPS = 11;
  localparam int SMALL_MAPS = 8;
  localparam int OUT_PINS = 22;
  localparam int SMALL_OUT_PINS = 16;
  // Register byte offsets and word indices
  localparam int IDX_W = 4;
  localparam int NUM_REGS = 13;
  localparam logic [31:0] OFS_SPI = 32'h0000_0000;
  localparam logic [31:0] OFS_CAN = 32'h0000_0004;
  localparam logic [31:0] OFS_OUT0 = 32'h0000_0008;
  localparam logic [IDX_W-1:0] IDX_SPI = OFS_SPI[IDX_W+1:2];
  localparam logic [IDX_W-1:0] IDX_CAN = OFS_CAN[IDX_W+1:2];
  localparam logic [IDX_W-1:0] IDX_OUT0 = OFS_OUT0[IDX_W+1:2];
  // Bus encodings
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic RESP_OKAY = 1'b0;
endpackage : pin_select_pkg

/* File: rtl/reg_access_if.sv */
// Register access carrier between bus port and register file
`timescale 1ns/1ns
interface reg_access_if
  import pin_select_pkg::*;
;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [REG_W-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0] rd_data;

  modport port (output wr_en, output wr_idx, output wr_data, output rd_idx,
                input rd_data);
  modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx,
                output rd_data);
endinterface : reg_access_if

/* File: rtl/ahb_reg_port.sv */
// AHB-Lite slave front end, zero wait states
`timescale 1ns/1ns
module ahb_reg_port
  import pin_select_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout_q,
  output logic hresp_q,
  output logic [31:0] hrdata_q,
  // Register side
  reg_access_if.port ra
);
  logic wr_pend_q, wr_pend_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [31:0] hrdata_d;
  logic take;
  logic hit;

  function automatic logic addr_hit(input logic [31:0] a);
    return (a[31:IDX_W+2] == '0) && (a[1:0] == 2'h0) && (int'(a[IDX_W+1:2]) < NUM_REGS);
  endfunction : addr_hit

  assign take = hsel && htrans[1] && hready;
  assign hit = addr_hit(haddr);
  assign ra.rd_idx = haddr[IDX_W+1:2];
  // Write lands at the end of its data phase
  assign ra.wr_en = wr_pend_q;
  assign ra.wr_idx = idx_q;
  assign ra.wr_data = hwdata[REG_W-1:0];

  // Read data loaded at the address phase edge, from post-write values
  always_comb begin
    wr_pend_d = take && hwrite && (hsize == SIZE_WORD) && hit;
    idx_d = take ? haddr[IDX_W+1:2] : idx_q;
    hrdata_d = hrdata_q;
    if (take && !hwrite) begin
      hrdata_d = hit ? ra.rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      idx_q <= '0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= RESP_OKAY;
    end else begin
      wr_pend_q <= wr_pend_d;
      idx_q <= idx_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= RESP_OKAY;
    end
  end
endmodule : ahb_reg_port

/* File: rtl/remappable_pin_select.sv */
// Remappable pin select: input selectors, output function maps, registers
//
// Notes on behaviour
// R1 - Selector value n, 0 to 25, routes remappable pin n to the input.
// R2 - Selector all ones ties the peripheral input low, no pin connected.
// R3 - SPI2 slave select comes from the pin chosen by select bits 4 to 0.
// R4 - CAN receive comes from pin chosen by bits 4 to 0; bits 15 to 5 unused.
// R5 - Without a CAN controller the CAN selector register has no effect.
// R6 - Each output map: even pin field at 4:0, odd pin field at 12:8.
// R7 - Output map bits 15:13 and 7:5 read zero and ignore writes.
// R8 - Output maps for pins 16 to 21 exist only on 44-pin parts.
// R9 - Output field zero assigns no function; pin stays under port control.
`timescale 1ns/1ns
module remappable_pin_select
  import pin_select_pkg::*;
#(
  parameter int NUM_PINS = 26,
  parameter bit HAS_CAN = 1'b1,
  parameter bit PIN44 = 1'b1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Remappable pins and peripheral functions
  input wire logic [NUM_PINS-1:0] remappable_pin,
  input wire logic [FUNC_CNT-1:0] periph_out,
  output logic [OUT_PINS-1:0] pin_out,
  output logic [OUT_PINS-1:0] pin_periph_en,
  // Peripheral inputs
  output logic spi2_slave_select_in,
  output logic can_receive_in
);
  reg_access_if ra ();

  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout_q(hreadyout),
    .hresp_q(hresp),
    .hrdata_q(hrdata),
    .ra(ra)
  );

  logic [SEL_W-1:0] spi_sel_q, spi_sel_d;
  logic [SEL_W-1:0] can_sel_q, can_sel_d;
  logic [SEL_W-1:0] fld_q [OUT_PINS];
  logic [SEL_W-1:0] fld_d [OUT_PINS];
  logic spi_in_q, spi_in_d;
  logic can_in_q, can_in_d;
  logic [OUT_PINS-1:0] pin_out_q, pin_out_d;
  logic [OUT_PINS-1:0] pin_en_q, pin_en_d;
  logic [31:0] rd_word;

  function automatic logic pick_pin(input logic [SEL_W-1:0] sel,
                                    input logic [NUM_PINS-1:0] pins);
    // Undefined codes above the last pin behave like the tied code
    if (int'(sel) < NUM_PINS) begin
      return pins[sel];
    end
    return 1'b0;
  endfunction : pick_pin

  function automatic logic [IDX_W-1:0] map_idx(input int k);
    return IDX_OUT0 + IDX_W'(k);
  endfunction : map_idx

  function automatic logic map_live(input int k);
    return PIN44 || (k < SMALL_MAPS);
  endfunction : map_live

  function automatic logic [REG_W-1:0] pair_word(input logic [SEL_W-1:0] lo,
                                                 input logic [SEL_W-1:0] hi);
    logic [REG_W-1:0] w;
    w = '0;
    w[LO_FIELD_LSB +: SEL_W] = lo;
    w[HI_FIELD_LSB +: SEL_W] = hi;
    return w;
  endfunction : pair_word

  // Register writes
  always_comb begin
    spi_sel_d = spi_sel_q;
    can_sel_d = can_sel_q;
    fld_d = fld_q;
    if (ra.wr_en) begin
      if (ra.wr_idx == IDX_SPI) begin
        spi_sel_d = ra.wr_data[SEL_W-1:0]; // see R3
      end
      // Without the controller the selector stays at its tied reset value
      if (ra.wr_idx == IDX_CAN && HAS_CAN) begin
        can_sel_d = ra.wr_data[SEL_W-1:0]; // see R4 see R5
      end
      for (int k = 0; k < NUM_MAPS; k++) begin
        if (ra.wr_idx == map_idx(k) && map_live(k)) begin // see R8
          fld_d[2*k] = ra.wr_data[LO_FIELD_LSB +: SEL_W]; // see R6
          fld_d[2*k+1] = ra.wr_data[HI_FIELD_LSB +: SEL_W]; // see R6 see R7
        end
      end
    end
  end

  // Read mux from post-write values, so a read right after a write sees it
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ra.rd_idx == IDX_SPI) begin
      rd_word = 32'(spi_sel_d);
    end
    if (ra.rd_idx == IDX_CAN && HAS_CAN) begin
      rd_word = 32'(can_sel_d); // see R5
    end
    for (int k = 0; k < NUM_MAPS; k++) begin
      if (ra.rd_idx == map_idx(k) && map_live(k)) begin
        rd_word = 32'(pair_word(fld_d[2*k], fld_d[2*k+1])); // see R7
      end
    end
  end
  assign ra.rd_data = rd_word;

  // Routing, one register stage from pin to peripheral and back
  always_comb begin
    spi_in_d = pick_pin(spi_sel_q, remappable_pin); // see R1 see R2 see R3
    can_in_d = HAS_CAN ? pick_pin(can_sel_q, remappable_pin) : 1'b0; // see R4 see R5
    for (int p = 0; p < OUT_PINS; p++) begin
      pin_en_d[p] = (fld_q[p] != FUNC_NONE); // see R9
      pin_out_d[p] = pin_en_d[p] && periph_out[fld_q[p]];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spi_sel_q <= SEL_RESET;
      can_sel_q <= SEL_RESET;
      fld_q <= '{default: FIELD_RESET};
      spi_in_q <= 1'b0;
      can_in_q <= 1'b0;
      pin_out_q <= '0;
      pin_en_q <= '0;
    end else begin
      spi_sel_q <= spi_sel_d;
      can_sel_q <= can_sel_d;
      fld_q <= fld_d;
      spi_in_q <= spi_in_d;
      can_in_q <= can_in_d;
      pin_out_q <= pin_out_d;
      pin_en_q <= pin_en_d;
    end
  end

  assign spi2_slave_select_in = spi_in_q;
  assign can_receive_in = can_in_q;
  assign pin_out = pin_out_q;
  assign pin_periph_en = pin_en_q;

  // Checks
  logic hi_fields_zero;
  always_comb begin
    hi_fields_zero = 1'b1;
    for (int p = SMALL_OUT_PINS; p < OUT_PINS; p++) begin
      if (fld_q[p] != FUNC_NONE) begin
        hi_fields_zero = 1'b0;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence spi_write_s;
    ra.wr_en && ra.wr_idx == IDX_SPI;
  endsequence

  sequence spi_pin_sel_s;
    spi_sel_q < 5'h1a;
  endsequence

  spi_route_a: assert property (spi_pin_sel_s |=> // see R1
    spi2_slave_select_in == $past(remappable_pin[spi_sel_q]))
    else $error("SPI2 select input does not follow the chosen pin");

  spi_tied_a: assert property ((spi_sel_q == SEL_TIED) [*2] |=> // see R2
    !spi2_slave_select_in)
    else $error("Tied SPI2 select input is not low");

  spi_write_a: assert property (spi_write_s |=> // see R3
    spi_sel_q == $past(ra.wr_data[4:0]) ##1
    spi2_slave_select_in == $past(remappable_pin[spi_sel_q]))
    else $error("SPI2 selector write does not steer the input");

  can_route_a: assert property (HAS_CAN && can_sel_q < 5'h1a |=> // see R4
    can_receive_in == $past(remappable_pin[can_sel_q]))
    else $error("CAN receive input does not follow the chosen pin");

  can_absent_a: assert property (!HAS_CAN |-> // see R5
    can_sel_q == SEL_RESET && !can_receive_in)
    else $error("CAN selector has effect without a controller");

  field_write_a: assert property (ra.wr_en && ra.wr_idx == IDX_OUT0 |=> // see R6
    fld_q[0] == $past(ra.wr_data[4:0]) && fld_q[1] == $past(ra.wr_data[12:8]))
    else $error("Output map fields are not taken from bits 4:0 and 12:8");

  reserved_read_a: assert property (ra.rd_idx >= IDX_OUT0 |-> // see R7
    ra.rd_data[15:13] == 3'h0 && ra.rd_data[7:5] == 3'h0 && ra.rd_data[31:16] == 16'h0000)
    else $error("Unused output map bits do not read zero");

  small_part_a: assert property (!PIN44 |-> hi_fields_zero) // see R8
    else $error("Pins 16 to 21 mapped on a small part");

  idle_pin_a: assert property (fld_q[0] == FUNC_NONE |=> // see R9
    !pin_periph_en[0] && !pin_out[0])
    else $error("Pin with no function is still driven by a peripheral");

  func_drive_a: assert property (fld_q[1] != FUNC_NONE |=> // see R6
    pin_periph_en[1] && pin_out[1] == $past(periph_out[fld_q[1]]))
    else $error("Mapped pin does not carry its peripheral output");

  // Register side and per-pin checks
  sequence can_write_s;
    HAS_CAN && ra.wr_en && ra.wr_idx == IDX_CAN;
  endsequence

  can_tied_a: assert property ((can_sel_q == SEL_TIED) [*2] |=> // see R2
    !can_receive_in)
    else $error("Tied CAN receive input is not low");

  // Codes past the last pin must never leak a pin level
  spi_undef_a: assert property (int'(spi_sel_q) >= NUM_PINS |=> // see R1
    !spi2_slave_select_in)
    else $error("SPI2 select input follows a code beyond the last pin");

  spi_hold_a: assert property (!(ra.wr_en && ra.wr_idx == IDX_SPI) |=> // see R3
    $stable(spi_sel_q))
    else $error("SPI2 selector changed without a write");

  can_write_a: assert property (can_write_s |=> // see R4
    can_sel_q == $past(ra.wr_data[4:0]))
    else $error("CAN selector write is not taken from bits 4:0");

  can_hold_a: assert property (!(ra.wr_en && ra.wr_idx == IDX_CAN) |=> // see R4
    $stable(can_sel_q))
    else $error("CAN selector changed without a write");

  sel_unused_a: assert property (ra.rd_idx == IDX_SPI || ra.rd_idx == IDX_CAN |-> // see R4
    ra.rd_data[31:5] == 27'h000_0000)
    else $error("Unused input selector bits do not read zero");

  can_read_a: assert property (!HAS_CAN && ra.rd_idx == IDX_CAN |-> // see R5
    ra.rd_data == 32'h0000_0000)
    else $error("CAN selector readable without a controller");

  small_read_a: assert property (!PIN44 && ra.rd_idx >= IDX_OUT0 + SMALL_MAPS |-> // see R8
    ra.rd_data == 32'h0000_0000)
    else $error("Output maps for pins 16 to 21 readable on a small part");

  top_map_a: assert property ( // see R6
    PIN44 && ra.wr_en && ra.wr_idx == IDX_OUT0 + NUM_MAPS - 1 |=>
    fld_q[OUT_PINS-2] == $past(ra.wr_data[4:0]) &&
    fld_q[OUT_PINS-1] == $past(ra.wr_data[12:8]))
    else $error("Last output map fields are not taken from bits 4:0 and 12:8");

  map_hold_a: assert property (!(ra.wr_en && ra.wr_idx == IDX_OUT0 + 1) |=> // see R6
    $stable(fld_q[2]) && $stable(fld_q[3]))
    else $error("Output map fields changed without a write");

  unmapped_read_a: assert property (ra.rd_idx >= NUM_REGS |-> // see R7
    ra.rd_data == 32'h0000_0000)
    else $error("Unmapped register index reads nonzero");

  write_size_a: assert property (ra.wr_en |->
    $past(hsize) == SIZE_WORD && $past(hwrite))
    else $error("Register write without a word write address phase");

  bus_ready_a: assert property (hreadyout && hresp == RESP_OKAY)
    else $error("Register bus inserted a wait state or an error");

  // Per-pin enable and idle level, one pair for every output pin
  for (genvar p = 0; p < OUT_PINS; p++) begin : g_pin_chk
    pin_enable_a: assert property ( // see R9
      pin_periph_en[p] == ($past(fld_q[p]) != FUNC_NONE))
      else $error("Pin enable does not match its function field");

    pin_idle_a: assert property ($past(fld_q[p]) == FUNC_NONE |-> !pin_out[p]) // see R9
      else $error("Pin with no function is not held low");
  end
endmodule : remappable_pin_select

/* File: tb/remappable_pin_select_tb.sv */
// Self-checking bench for the remappable pin select block
`timescale 1ns/1ns
module remappable_pin_select_tb
  import pin_select_pkg::*;
;
  localparam logic [31:0] PO_PAT = 32'h3c96_5a6e;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [25:0] pins = 26'h3ff_ffff;
  logic [31:0] po = 32'h0000_0000;
  logic [21:0] pin_out;
  logic [21:0] pin_periph_en;
  logic spi_in;
  logic can_in;
  logic [31:0] hrdata_s;
  logic [21:0] pin_en_s;
  logic can_in_s;
  int bad_count = 0;
  int tests_run = 0;

  always #20 hclk = ~hclk;

  // hready is looped back from the full-size slave uut
  remappable_pin_select uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .remappable_pin(pins),
    .periph_out(po), .pin_out(pin_out), .pin_periph_en(pin_periph_en),
    .spi2_slave_select_in(spi_in), .can_receive_in(can_in)
  );

  // Small part without the CAN controller, on the same bus
  remappable_pin_select #(.HAS_CAN(1'b0), .PIN44(1'b0)) uut_small (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(hrdata_s), .remappable_pin(pins),
    .periph_out(po), .pin_out(), .pin_periph_en(pin_en_s),
    .spi2_slave_select_in(), .can_receive_in(can_in_s)
  );

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Single word transfer; entered just after a rising edge
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= SIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(x, exp);
  endtask : rdchk

  // Register commit plus one routing flop, with margin
  task settle();
    repeat (3) @(posedge hclk);
  endtask : settle

  task test_reset();
    chk({31'h0, spi_in}, 32'h0000_0000);
    chk({31'h0, can_in}, 32'h0000_0000);
    chk({10'h0, pin_periph_en}, 32'h0000_0000);
    rdchk(OFS_SPI, 32'h0000_001f);
    rdchk(OFS_CAN, 32'h0000_001f);
    chk(hrdata_s, 32'h0000_0000);
  endtask : test_reset

  task test_inputs();
    for (int n = 0; n < 26; n++) begin
      pins <= (26'h1 << n) | (26'h1 << (25 - n));
      wr(OFS_SPI, n);
      wr(OFS_CAN, 25 - n);
      settle();
      chk({31'h0, spi_in}, 32'h0000_0001);
      chk({31'h0, can_in}, 32'h0000_0001);
      chk({31'h0, can_in_s}, 32'h0000_0000);
      // Inverted levels catch a selector that is off by one
      pins <= ~pins;
      settle();
      chk({31'h0, spi_in}, 32'h0000_0000);
      chk({31'h0, can_in}, 32'h0000_0000);
    end
    pins <= 26'h3ff_ffff;
    wr(OFS_SPI, 32'h0000_001a);
    settle();
    chk({31'h0, spi_in}, 32'h0000_0000);
    wr(OFS_SPI, {27'h0, SEL_TIED});
    wr(OFS_CAN, 32'hffff_ffff);
    rdchk(OFS_CAN, 32'h0000_001f);
    chk(hrdata_s, 32'h0000_0000);
    settle();
    chk({31'h0, spi_in}, 32'h0000_0000);
    chk({31'h0, can_in}, 32'h0000_0000);
  endtask : test_inputs

  task test_outputs();
    logic [4:0] lo;
    logic [4:0] hi;
    logic [21:0] exp;
    logic [31:0] a;
    po <= PO_PAT;
    for (int k = 0; k < 11; k++) begin
      lo = 5'(k + 1);
      hi = 5'(k + 20);
      a = OFS_OUT0 + 32'(4 * k);
      rdchk(a, 32'h0000_0000);
      wr(a, {16'hffff, 3'h7, hi, 3'h7, lo});
      rdchk(a, {16'h0000, 3'h0, hi, 3'h0, lo});
      chk(hrdata_s, (k < SMALL_MAPS) ? {16'h0000, 3'h0, hi, 3'h0, lo} : 32'h0000_0000);
      exp[2 * k] = PO_PAT[lo];
      exp[2 * k + 1] = PO_PAT[hi];
    end
    settle();
    chk({10'h0, pin_out}, {10'h0, exp});
    chk({10'h0, pin_periph_en}, 32'h003f_ffff);
    chk({10'h0, pin_en_s}, 32'h0000_ffff);
    po <= ~PO_PAT;
    settle();
    chk({10'h0, pin_out}, {10'h0, ~exp});
    wr(OFS_OUT0, 32'h0000_0000);
    settle();
    chk({30'h0, pin_periph_en[1:0]}, 32'h0000_0000);
    chk({30'h0, pin_out[1:0]}, 32'h0000_0000);
    chk({10'h0, pin_en_s}, 32'h0000_fffc);
  endtask : test_outputs

  task test_unmapped();
    wr(32'h0000_0040, 32'h0000_ffff);
    rdchk(32'h0000_0040, 32'h0000_0000);
    rdchk(OFS_SPI, 32'h0000_001f);
    chk({31'h0, hresp}, {31'h0, RESP_OKAY});
  endtask : test_unmapped

  task complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Whole run needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_inputs();
    test_outputs();
    test_unmapped();
    complete_run();
  end
endmodule : remappable_pin_select_tb
